// ### rtl/dpp_pkg.sv
// Constants and types shared by the downstream port power control block
package dpp_pkg;

  // Number of downstream ports served by the block
  localparam int unsigned NUM_PORTS   = 4;
  // Default width of the generic strap bus captured at reset
  localparam int unsigned STRAP_W_DEF = 4;

  // Synchroniser depth for every pin input
  localparam int unsigned SYNC_STAGES = 2;
  // Cycles a pin must be released before its sensed level is trusted
  localparam int unsigned SENSE_SETTLE = 3;

  // Values after reset: pins are pulled up, so synced inputs idle high
  localparam logic        PIN_IDLE_RST = 1'h1;
  localparam logic        GANG_RST     = 1'h0;
  localparam logic [3:0]  PORT_OC_RST  = 4'h0;
  localparam logic        PIN_OUT_RST  = 1'h0;
  // Output enable is active low: 1 releases the pin
  localparam logic        PIN_OE_N_RST = 1'h1;

  // Reset and capture sequencing, one-hot
  typedef enum logic [2:0] {
    DPP_ST_HOLD    = 3'h1,
    DPP_ST_CAPTURE = 3'h2,
    DPP_ST_RUN     = 3'h4
  } dpp_state_t;

endpackage : dpp_pkg

// ### rtl/dpp_sync.sv
// Two-flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module dpp_sync #(
  parameter int unsigned W       = 1,
  parameter logic        RST_VAL = 1'h1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Asynchronous input and synchronised output
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stage1   <= {W{RST_VAL}};
      sync_out <= {W{RST_VAL}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // dpp_sync

// ### rtl/dpp_port_power.sv
// Downstream port power enable and overcurrent sense with strap capture
// Behaviour
// - Capture straps at reset and reset_n rise
// - Output mode drives high for power on
// - Input mode pin reports port overcurrent
// - Gang strap high selects gang mode
// - Gang mode uses gang pin for power
`timescale 1ns/1ps
module dpp_port_power #(
  parameter int unsigned STRAP_W = dpp_pkg::STRAP_W_DEF
) (
  // Clock and reset
  input  wire logic                           mclk,
  input  wire logic                           sys_rst,
  // External chip reset pin, active low
  input  wire logic                           ext_reset_n,
  // Generic configuration straps
  input  wire logic [STRAP_W-1:0]             strap_in,
  output logic      [STRAP_W-1:0]             strap_value,
  // Port 1 control pin
  input  wire logic                           port1_power_ctl_in,
  output logic                                port1_power_ctl_out,
  output logic                                port1_power_ctl_oe_n,
  // Port 2 control pin
  input  wire logic                           port2_power_ctl_in,
  output logic                                port2_power_ctl_out,
  output logic                                port2_power_ctl_oe_n,
  // Port 3 control pin
  input  wire logic                           port3_power_ctl_in,
  output logic                                port3_power_ctl_out,
  output logic                                port3_power_ctl_oe_n,
  // Port 4 control pin
  input  wire logic                           port4_power_ctl_in,
  output logic                                port4_power_ctl_out,
  output logic                                port4_power_ctl_oe_n,
  // Gang select and gang power pin
  input  wire logic                           gang_power_select_in,
  output logic                                gang_power_select_out,
  output logic                                gang_power_select_oe_n,
  // Hub controller requests, bit 0 is port 1
  input  wire logic [dpp_pkg::NUM_PORTS-1:0]  port_power_req,
  input  wire logic [dpp_pkg::NUM_PORTS-1:0]  port_sense_sel,
  input  wire logic [dpp_pkg::NUM_PORTS-1:0]  oc_clear,
  // Status towards the hub controller
  output logic                                gang_mode,
  output logic                                in_reset,
  output logic      [dpp_pkg::NUM_PORTS-1:0]  port_oc,
  output logic      [dpp_pkg::NUM_PORTS-1:0]  oc_event,
  output logic      [dpp_pkg::NUM_PORTS-1:0]  oc_sticky
);
  import dpp_pkg::*;

  localparam int unsigned NP = NUM_PORTS;
  localparam int unsigned SW = STRAP_W + NP + 2;

  dpp_state_t        state;
  dpp_state_t        next_state;
  logic [SW-1:0]     raw_pins;
  logic [SW-1:0]     sync_pins;
  logic [STRAP_W-1:0] strap_s;
  logic [NP-1:0]     pin_s;
  logic              gang_s;
  logic              rst_n_s;
  logic              rst_n_d;
  logic              rst_rise;
  logic [SYNC_STAGES-1:0] fill;
  logic              fill_done;
  logic [NP-1:0]     pin_out;
  logic [NP-1:0]     pin_oe_n;
  logic              gang_out;
  logic              gang_oe_n;
  logic [NP-1:0]     next_pin_out;
  logic [NP-1:0]     next_pin_oe_n;
  logic              next_gang_out;
  logic              next_gang_oe_n;
  logic [NP-1:0]     drive_sel;
  logic [NP-1:0]     released;
  logic [NP-1:0]     sense_ok;
  logic              gang_sense;
  logic              gang_ok;
  logic [NP-1:0]     next_oc;
  logic [SENSE_SETTLE-1:0] settle [NP:0];

  // All pin levels cross into the core clock through two flip-flops
  assign raw_pins = {ext_reset_n, gang_power_select_in, port4_power_ctl_in,
                     port3_power_ctl_in, port2_power_ctl_in, port1_power_ctl_in, strap_in};

  dpp_sync #(
    .W       (SW),
    .RST_VAL (PIN_IDLE_RST)
  ) u_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (raw_pins),
    .sync_out (sync_pins)
  );

  // Split the synchronised vector back into its groups
  assign strap_s = sync_pins[STRAP_W-1:0];
  assign pin_s   = sync_pins[STRAP_W +: NP];
  assign gang_s  = sync_pins[STRAP_W+NP];
  assign rst_n_s = sync_pins[STRAP_W+NP+1];

  // Rising edge of the synchronised external reset
  assign rst_rise = rst_n_s & ~rst_n_d;

  // Synchroniser shows its reset value until real pin levels have crossed it;
  // capturing earlier would latch that reset value instead of the straps
  assign fill_done = fill[SYNC_STAGES-1];

  // Sequencer: hold while sys_rst is high or ext_reset_n is low, capture once on release
  always_comb begin
    next_state = state;
    case (state)
      DPP_ST_HOLD: begin
        if (rst_n_s && fill_done) begin
          next_state = DPP_ST_CAPTURE;
        end
      end
      DPP_ST_CAPTURE: begin
        next_state = rst_n_s ? DPP_ST_RUN : DPP_ST_HOLD;
      end
      DPP_ST_RUN: begin
        if (!rst_n_s) begin
          next_state = DPP_ST_HOLD;
        end
      end
      default: begin
        next_state = DPP_ST_HOLD;
      end
    endcase
  end

  // State register, edge history of the external reset and synchroniser fill
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state   <= DPP_ST_HOLD;
      rst_n_d <= PIN_IDLE_RST;
      fill    <= '0;
    end else begin
      state   <= next_state;
      rst_n_d <= rst_n_s;
      fill    <= {fill[SYNC_STAGES-2:0], 1'h1};
    end
  end

  // Straps and gang strap are caught only in the capture state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      strap_value <= '0;
      gang_mode   <= GANG_RST;
    end else if (state == DPP_ST_CAPTURE) begin
      strap_value <= strap_s;
      gang_mode   <= gang_s;
    end
  end

  // Pin direction: drive only in run, per port unless gang mode owns power
  assign drive_sel     = (state == DPP_ST_RUN && !gang_mode) ? ~port_sense_sel : '0;
  assign next_pin_out  = port_power_req & drive_sel;
  assign next_pin_oe_n = ~drive_sel;
  assign gang_sense    = |port_sense_sel;
  assign next_gang_out  = (state == DPP_ST_RUN && gang_mode) ? |port_power_req : 1'h0;
  assign next_gang_oe_n = !(state == DPP_ST_RUN && gang_mode && !gang_sense);

  // Registered pin drivers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_out   <= {NP{PIN_OUT_RST}};
      pin_oe_n  <= {NP{PIN_OE_N_RST}};
      gang_out  <= PIN_OUT_RST;
      gang_oe_n <= PIN_OE_N_RST;
    end else begin
      pin_out   <= next_pin_out;
      pin_oe_n  <= next_pin_oe_n;
      gang_out  <= next_gang_out;
      gang_oe_n <= next_gang_oe_n;
    end
  end

  assign port1_power_ctl_out    = pin_out[0];
  assign port2_power_ctl_out    = pin_out[1];
  assign port3_power_ctl_out    = pin_out[2];
  assign port4_power_ctl_out    = pin_out[3];
  assign port1_power_ctl_oe_n   = pin_oe_n[0];
  assign port2_power_ctl_oe_n   = pin_oe_n[1];
  assign port3_power_ctl_oe_n   = pin_oe_n[2];
  assign port4_power_ctl_oe_n   = pin_oe_n[3];
  assign gang_power_select_out  = gang_out;
  assign gang_power_select_oe_n = gang_oe_n;
  assign in_reset               = (state != DPP_ST_RUN);

  // Released-in-sense flags for the port pins
  assign released = port_sense_sel & pin_oe_n & {NP{state == DPP_ST_RUN}};

  // A pin is trusted only after its level has crossed the synchroniser
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i <= NP; i++) begin
        settle[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NP; i++) begin
        settle[i] <= {settle[i][SENSE_SETTLE-2:0], released[i] & ~gang_mode};
      end
      settle[NP] <= {settle[NP][SENSE_SETTLE-2:0], gang_oe_n & gang_mode & gang_sense};
    end
  end

  // Overcurrent decode: low pulled-up level means fault
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      sense_ok[i] = &settle[i];
    end
  end
  assign gang_ok = &settle[NP];
  assign next_oc = gang_mode ? {NP{gang_ok & ~gang_s}} : (sense_ok & ~pin_s);

  // Level, rising-edge pulse and sticky flag; a new fault beats a clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      port_oc   <= PORT_OC_RST;
      oc_event  <= PORT_OC_RST;
      oc_sticky <= PORT_OC_RST;
    end else begin
      port_oc   <= next_oc;
      oc_event  <= next_oc & ~port_oc;
      oc_sticky <= (oc_sticky & ~oc_clear) | (next_oc & ~port_oc);
    end
  end

  // Checks on the logic above
  sequence s_capture;
    state == DPP_ST_CAPTURE;
  endsequence

  sequence s_running;
    state == DPP_ST_RUN [*2];
  endsequence

  a_strap_capture: assert property (@(posedge mclk) disable iff (sys_rst)
    s_capture |=> (strap_value == $past(strap_s)))
    else $error("strap value not captured at reset release");

  a_strap_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    s_running |-> $stable(strap_value) && $stable(gang_mode))
    else $error("strap value changed outside capture");

  a_port_drive: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == DPP_ST_RUN && !gang_mode) |=>
      ((pin_oe_n == $past(port_sense_sel)) &&
       (pin_out == ($past(port_power_req) & ~$past(port_sense_sel)))))
    else $error("port pin not driven from power request");

  a_gang_select: assert property (@(posedge mclk) disable iff (sys_rst)
    s_capture |=> (gang_mode == $past(gang_s)))
    else $error("gang mode does not follow gang strap");

  a_reset_rise: assert property (@(posedge mclk) disable iff (sys_rst)
    rst_rise |=> s_capture)
    else $error("external reset rise did not start a capture");

  a_gang_owns: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == DPP_ST_RUN && gang_mode && !gang_sense) |=>
      (&pin_oe_n) && !gang_oe_n && (gang_out == $past(|port_power_req)))
    else $error("gang pin not used as common power pin");

  a_oc_level: assert property (@(posedge mclk) disable iff (sys_rst)
    !gang_mode |=> (port_oc == $past(sense_ok & ~pin_s)))
    else $error("port overcurrent not reported");

  a_oc_polarity: assert property (@(posedge mclk) disable iff (sys_rst)
    (!gang_mode && (pin_s == 4'hF)) |=> (port_oc == 4'h0))
    else $error("high sensed level reported as overcurrent");

  a_oc_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
    (|oc_event) |-> ((oc_sticky & oc_event) == oc_event) && (port_oc & oc_event) == oc_event)
    else $error("overcurrent event not latched");

endmodule // dpp_port_power

// ### verif/dpp_ext_model.sv
// External power switches, current monitors and gang strap resistor
`timescale 1ns/1ps
module dpp_ext_model (
  // Pin drive from the block, bit 4 is the gang pin
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe_n,
  // Monitor faults and the gang strap resistor level
  input  wire logic [4:0] fault,
  input  wire logic       gang_strap,
  // Resolved pin levels
  output logic      [4:0] pin_lvl
);
  // Released port pins rest on the pull-up; a faulting monitor pulls low
  assign pin_lvl[3:0] = (~pin_oe_n[3:0] & pin_out[3:0]) | (pin_oe_n[3:0] & ~fault[3:0]);
  // Released gang pin shows its strap resistor unless its monitor pulls low
  assign pin_lvl[4] = pin_oe_n[4] ? (gang_strap & ~fault[4]) : pin_out[4];
endmodule // dpp_ext_model

// ### verif/tb_top.sv
// Self-checking bench for the port power control block
`timescale 1ns/1ps
module tb_top;
  import dpp_pkg::*;
  logic       mclk = 0, sys_rst = 1, ext_reset_n = 1, gang_strap = 0, gang_mode, in_reset;
  logic [3:0] strap_in = 4'hA, req = 4'h0, sel = 4'h0, clr = 4'h0;
  logic [3:0] strap_value, port_oc, oc_event, oc_sticky;
  logic [4:0] fault = 5'h00, pin_out, pin_oe_n, pin_lvl;
  logic [15:0] rows [4] = '{16'h5050, 16'hF0F0, 16'hA5A5, 16'hFF0F};
  int         error_cnt = 0;
  int         compares = 0;
  // Clock at 4 ns
  always #2 mclk = ~mclk;
  dpp_port_power dpp_port_power_i (
    .mclk(mclk), .sys_rst(sys_rst), .ext_reset_n(ext_reset_n),
    .strap_in(strap_in), .strap_value(strap_value),
    .port1_power_ctl_in(pin_lvl[0]), .port1_power_ctl_out(pin_out[0]),
    .port1_power_ctl_oe_n(pin_oe_n[0]),
    .port2_power_ctl_in(pin_lvl[1]), .port2_power_ctl_out(pin_out[1]),
    .port2_power_ctl_oe_n(pin_oe_n[1]),
    .port3_power_ctl_in(pin_lvl[2]), .port3_power_ctl_out(pin_out[2]),
    .port3_power_ctl_oe_n(pin_oe_n[2]),
    .port4_power_ctl_in(pin_lvl[3]), .port4_power_ctl_out(pin_out[3]),
    .port4_power_ctl_oe_n(pin_oe_n[3]),
    .gang_power_select_in(pin_lvl[4]), .gang_power_select_out(pin_out[4]),
    .gang_power_select_oe_n(pin_oe_n[4]),
    .port_power_req(req), .port_sense_sel(sel), .oc_clear(clr),
    .gang_mode(gang_mode), .in_reset(in_reset), .port_oc(port_oc),
    .oc_event(oc_event), .oc_sticky(oc_sticky)
  );
  dpp_ext_model dpp_ext_model_i (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .fault(fault),
    .gang_strap(gang_strap), .pin_lvl(pin_lvl)
  );
  // Compare one vector result
  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Let n edges pass, then sample at the falling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  // Wait for the sequencer to reach run, bounded
  task automatic wait_run();
    for (int i = 0; i < 20 && in_reset !== 1'b0; i++) cyc(0);
    chk("in_reset", 4'h0, {3'h0, in_reset});
  endtask
  // Verdict and end of run
  task automatic end_sim();
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #20000;
    error_cnt++;
    end_sim();
  end
  // Main sequence
  initial begin
    cyc(3);
    chk("oe_n_rst", 4'hF, pin_oe_n[3:0]);
    chk("strap_rst", 4'h0, strap_value);
    @(posedge mclk) sys_rst <= 1'b0;
    cyc(0);
    wait_run();
    chk("strap_por", 4'hA, strap_value);
    chk("gang_off", 4'h0, {3'h0, gang_mode});
    // Individual mode rows: req, sense_sel, expected out, expected oe_n
    foreach (rows[i]) begin
      @(posedge mclk) begin
        req <= rows[i][15:12];
        sel <= rows[i][11:8];
      end
      cyc(5);
      chk("pin_out", rows[i][7:4], pin_out[3:0]);
      chk("pin_oe_n", rows[i][3:0], pin_oe_n[3:0]);
      chk("no_oc", 4'h0, port_oc);
    end
    // Overcurrent on port 2 while sensing
    @(posedge mclk) begin
      sel <= 4'h2;
      fault <= 5'h02;
    end
    for (int i = 0; i < 12 && port_oc[1] !== 1'b1; i++) cyc(0);
    chk("oc_level", 4'h2, port_oc);
    chk("oc_pulse", 4'h2, oc_event);
    chk("oc_sticky", 4'h2, oc_sticky);
    cyc(0);
    chk("oc_pulse_end", 4'h0, oc_event);
    @(posedge mclk) fault <= 5'h00;
    cyc(5);
    chk("oc_gone", 4'h0, port_oc);
    chk("sticky_hold", 4'h2, oc_sticky);
    @(posedge mclk) clr <= 4'h2;
    @(posedge mclk) clr <= 4'h0;
    cyc(1);
    chk("sticky_clr", 4'h0, oc_sticky);
    // External reset: straps held while low, recaptured on rise
    @(posedge mclk) begin
      ext_reset_n <= 1'b0;
      req <= 4'h1;
      sel <= 4'h0;
    end
    cyc(4);
    @(posedge mclk) begin
      strap_in <= 4'h5;
      gang_strap <= 1'b1;
    end
    cyc(4);
    chk("strap_held", 4'hA, strap_value);
    chk("hold_oe_n", 4'hF, pin_oe_n[3:0]);
    @(posedge mclk) ext_reset_n <= 1'b1;
    cyc(0);
    wait_run();
    chk("strap_rcap", 4'h5, strap_value);
    chk("gang_on", 4'h1, {3'h0, gang_mode});
    // Gang mode power then gang overcurrent
    cyc(2);
    chk("gang_drive", 4'h1, {2'h0, pin_oe_n[4], pin_out[4]});
    chk("gang_ports", 4'hF, pin_oe_n[3:0]);
    @(posedge mclk) begin
      sel <= 4'h1;
      fault <= 5'h10;
    end
    cyc(8);
    chk("gang_rel", 4'h3, {2'h0, pin_oe_n[4], pin_out[4]});
    chk("gang_oc", 4'hF, port_oc);
    end_sim();
  end
endmodule // tb_top
